// ===== rtl/tac_regs.sv
`timescale 1ns/1ps
module tac_regs #(
  // Identification codes: values are arbitrary
  parameter logic [5:0] VERSION_CODE = 6'h01,
  parameter logic [5:0] DEVICE_CODE = 6'h02,
  parameter logic [3:0] MAKER_CODE = 4'h3
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [3:0] host_addr_i,
  input wire logic [15:0] host_wdata_i,
  output logic [15:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic pos_x_pin_i,
  input wire logic neg_x_pin_i,
  input wire logic test_enable_i,
  input wire logic conv_done_i,
  input wire logic [9:0] conv_result_i,
  output tac_pkg::tac_touch_ctl_t touch_o,
  output tac_pkg::tac_touch_mode_t touch_mode_o,
  output tac_pkg::tac_conv_ctl_t conv_o,
  output logic [7:0] conv_route_o,
  output logic conv_start_o,
  output tac_pkg::tac_mode_t mode_o
);

  tac_pkg::tac_state_t st_r;
  tac_pkg::tac_state_t st_nxt;

  function automatic logic [7:0] tac_route(input logic [2:0] sel);
    tac_route = 8'h01 << sel;
  endfunction : tac_route

  function automatic tac_pkg::tac_touch_mode_t tac_op_decode(
    input logic [1:0] op
  );
    tac_pkg::tac_touch_mode_t m;
    m.interrupt_mode = (op == 2'h0);
    m.pressure_mode = (op == 2'h1);
    m.position_mode = op[1];
    tac_op_decode = m;
  endfunction : tac_op_decode

  function automatic logic [15:0] tac_read(
    input tac_pkg::tac_state_t s,
    input logic [3:0] addr
  );
    logic [15:0] w;
    w = tac_pkg::TAC_WORD_ZERO;
    if (addr == tac_pkg::TAC_ADDR_TOUCH)
    begin
      w[tac_pkg::TAC_TP_POWER_LSB +: 4] = s.touch.power;
      w[tac_pkg::TAC_TP_GROUND_LSB +: 4] = s.touch.ground;
      w[tac_pkg::TAC_TP_OP_LSB +: 2] = s.touch.op_select;
      w[tac_pkg::TAC_TP_BIAS] = s.touch.bias_on;
      w[tac_pkg::TAC_TP_PX_DOWN] = ~s.px_s2; // R4
      w[tac_pkg::TAC_TP_MX_DOWN] = ~s.mx_s2; // R5
    end
    else if (addr == tac_pkg::TAC_ADDR_CONV_CTL)
    begin
      w[tac_pkg::TAC_CC_SYNC] = s.conv.sync_on;
      w[tac_pkg::TAC_CC_REF_PIN] = s.conv.internal_ref_to_pin;
      w[tac_pkg::TAC_CC_INPUT_LSB +: 3] = s.conv.input_select;
      w[tac_pkg::TAC_CC_EXT_REF] = s.conv.external_reference_select;
      w[tac_pkg::TAC_CC_START] = s.conv.start;
      w[tac_pkg::TAC_CC_POWER] = s.conv.power_on;
    end
    else if (addr == tac_pkg::TAC_ADDR_CONV_RES)
    begin
      w[tac_pkg::TAC_CR_DATA_LSB +: 10] = s.result; // R12
      w[tac_pkg::TAC_CR_DONE] = s.conversion_done; // R13
    end
    else if (addr == tac_pkg::TAC_ADDR_ID)
    begin
      w[5:0] = VERSION_CODE; // R14
      w[tac_pkg::TAC_ID_DEVICE_LSB +: 6] = DEVICE_CODE;
      w[tac_pkg::TAC_ID_MAKER_LSB +: 4] = MAKER_CODE;
    end
    else if (addr == tac_pkg::TAC_ADDR_MODE)
    begin
      w[tac_pkg::TAC_MD_AUDIO_TEST] = s.mode.audio_analog_test;
      w[tac_pkg::TAC_MD_TELECOM_ANALOG_TEST] = s.mode.telecom_analog_test;
      w[tac_pkg::TAC_MD_PROD_LSB +: 4] = s.mode.production_test_select;
      w[tac_pkg::TAC_MD_DYN_FLAG] = s.mode.dynamic_valid_flag_on;
      w[tac_pkg::TAC_MD_OFFSET] = s.mode.audio_offset_cancel;
      w[tac_pkg::TAC_MD_AUDIO_ORDER] = s.mode.audio_word_order;
      w[tac_pkg::TAC_MD_TEL_ORDER] = s.mode.telecom_word_order;
    end
    else if (addr == tac_pkg::TAC_ADDR_ONES)
    begin
      w = tac_pkg::TAC_WORD_ONES; // R22
    end
    else
    begin
      // Reserved slot and foreign addresses read zero
      w = tac_pkg::TAC_WORD_ZERO; // R21
    end
    tac_read = w;
  endfunction : tac_read

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.px_s1 = pos_x_pin_i;
    st_nxt.px_s2 = st_r.px_s1;
    st_nxt.mx_s1 = neg_x_pin_i;
    st_nxt.mx_s2 = st_r.mx_s1;
    st_nxt.test_s1 = test_enable_i;
    st_nxt.test_s2 = st_r.test_s1;
    st_nxt.conv_start = 1'b0;
    st_nxt.rvalid = host_rd_i;
    if (host_rd_i)
    begin
      st_nxt.rdata = tac_read(st_r, host_addr_i);
    end
    if (host_wr_i)
    begin
      if (host_addr_i == tac_pkg::TAC_ADDR_TOUCH)
      begin
        st_nxt.touch.power =
          host_wdata_i[tac_pkg::TAC_TP_POWER_LSB +: 4]; // R23
        st_nxt.touch.ground =
          host_wdata_i[tac_pkg::TAC_TP_GROUND_LSB +: 4]; // R1
        st_nxt.touch.op_select =
          host_wdata_i[tac_pkg::TAC_TP_OP_LSB +: 2]; // R2
        st_nxt.touch.bias_on = host_wdata_i[tac_pkg::TAC_TP_BIAS]; // R3
      end
      else if (host_addr_i == tac_pkg::TAC_ADDR_CONV_CTL)
      begin
        st_nxt.conv.sync_on = host_wdata_i[tac_pkg::TAC_CC_SYNC]; // R6
        st_nxt.conv.internal_ref_to_pin =
          host_wdata_i[tac_pkg::TAC_CC_REF_PIN]; // R7
        st_nxt.conv.input_select =
          host_wdata_i[tac_pkg::TAC_CC_INPUT_LSB +: 3]; // R8
        st_nxt.conv.external_reference_select =
          host_wdata_i[tac_pkg::TAC_CC_EXT_REF]; // R9
        st_nxt.conv.start = host_wdata_i[tac_pkg::TAC_CC_START];
        st_nxt.conv.power_on = host_wdata_i[tac_pkg::TAC_CC_POWER]; // R11
        // Only a rising start bit launches a conversion
        if (host_wdata_i[tac_pkg::TAC_CC_START] && !st_r.conv.start)
        begin
          st_nxt.conv_start = 1'b1; // R10
          st_nxt.conversion_done = 1'b0; // R13
        end
      end
      else if (host_addr_i == tac_pkg::TAC_ADDR_MODE)
      begin
        // Test bits change only with the test pin held high
        if (st_r.test_s2)
        begin
          st_nxt.mode.audio_analog_test =
            host_wdata_i[tac_pkg::TAC_MD_AUDIO_TEST]; // R15 R24
          st_nxt.mode.telecom_analog_test =
            host_wdata_i[tac_pkg::TAC_MD_TELECOM_ANALOG_TEST]; // R16 R24
          st_nxt.mode.production_test_select =
            host_wdata_i[tac_pkg::TAC_MD_PROD_LSB +: 4]; // R17 R24
        end
        st_nxt.mode.dynamic_valid_flag_on =
          host_wdata_i[tac_pkg::TAC_MD_DYN_FLAG]; // R18
        st_nxt.mode.audio_offset_cancel =
          host_wdata_i[tac_pkg::TAC_MD_OFFSET]; // R19
        st_nxt.mode.audio_word_order =
          host_wdata_i[tac_pkg::TAC_MD_AUDIO_ORDER]; // R20
        st_nxt.mode.telecom_word_order =
          host_wdata_i[tac_pkg::TAC_MD_TEL_ORDER]; // R20
      end
    end
    // Finished conversion wins over a clearing start
    if (conv_done_i)
    begin
      st_nxt.result = conv_result_i; // R12
      st_nxt.conversion_done = 1'b1; // R13
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      // Pins idle high: no false pen-down after reset
      st_r.px_s1 <= 1'b1;
      st_r.px_s2 <= 1'b1;
      st_r.mx_s1 <= 1'b1;
      st_r.mx_s2 <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign host_rdata_o = st_r.rdata;
  assign host_rvalid_o = st_r.rvalid;
  assign touch_o = st_r.touch;
  assign touch_mode_o = tac_op_decode(st_r.touch.op_select); // R2
  assign conv_o = st_r.conv;
  assign conv_route_o = tac_route(st_r.conv.input_select); // R8
  assign conv_start_o = st_r.conv_start;
  assign mode_o = st_r.mode;

  default clocking tac_cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  AST_GROUND_WRITE: // R1
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_TOUCH
    |=> touch_o.ground == $past(host_wdata_i[7:4]))
  else $error("ground enables do not follow write");

  AST_MODE_DECODE: // R2
  assert property ($onehot({touch_mode_o.interrupt_mode,
    touch_mode_o.pressure_mode, touch_mode_o.position_mode})
    && touch_mode_o.position_mode == touch_o.op_select[1]
    && touch_mode_o.pressure_mode == (touch_o.op_select == 2'h1))
  else $error("touch mode decode wrong");

  AST_BIAS_WRITE: // R3
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_TOUCH
    |=> touch_o.bias_on == $past(host_wdata_i[11]))
  else $error("bias does not follow write");

  AST_PX_READ: // R4
  assert property (host_rd_i && host_addr_i == tac_pkg::TAC_ADDR_TOUCH
    |=> host_rvalid_o && host_rdata_o[12] == !$past(st_r.px_s2))
  else $error("positive-x pen bit wrong");

  AST_MX_READ: // R5
  assert property (host_rd_i && host_addr_i == tac_pkg::TAC_ADDR_TOUCH
    |=> host_rdata_o[13] == !$past(st_r.mx_s2))
  else $error("negative-x pen bit wrong");

  AST_CONV_CTL_WRITE: // R6
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_CONV_CTL
    |=> conv_o.sync_on == $past(host_wdata_i[0])
    && conv_o.power_on == $past(host_wdata_i[15])
    && conv_o.external_reference_select == $past(host_wdata_i[5]))
  else $error("converter control not stored");

  AST_ROUTE: // R8
  assert property (conv_route_o == (8'h01 << conv_o.input_select))
  else $error("converter route wrong");

  AST_START_RISE: // R10
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_CONV_CTL
    && host_wdata_i[7] && !conv_o.start
    |=> conv_start_o ##1 !conv_start_o)
  else $error("start pulse missing or long");

  AST_START_NO_RISE: // R10
  assert property (conv_start_o |-> $past(!conv_o.start) && conv_o.start)
  else $error("start without rising bit");

  AST_DONE_SET: // R13
  assert property (conv_done_i |=> st_r.conversion_done
    && st_r.result == $past(conv_result_i))
  else $error("result or done flag not stored");

  AST_DONE_CLEAR: // R13
  assert property (conv_start_o && !$past(conv_done_i)
    |-> !st_r.conversion_done)
  else $error("done flag not cleared on start");

  AST_ONES_READ: // R22
  assert property (host_rd_i && host_addr_i == tac_pkg::TAC_ADDR_ONES
    |=> host_rdata_o == 16'hffff)
  else $error("all-ones register wrong");

  AST_RSVD_READ: // R21
  assert property (host_rd_i && host_addr_i == tac_pkg::TAC_ADDR_RSVD
    |=> host_rdata_o == 16'h0000)
  else $error("reserved slot not zero");

  AST_TEST_GATE: // R24
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_MODE
    && !st_r.test_s2
    |=> $stable(mode_o.production_test_select)
    && $stable(mode_o.audio_analog_test))
  else $error("test bits written without test pin");

  AST_ORDER_WRITE: // R20
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_MODE
    |=> mode_o.audio_word_order == $past(host_wdata_i[14])
    && mode_o.telecom_word_order == $past(host_wdata_i[15])
    && mode_o.audio_offset_cancel == $past(host_wdata_i[13]))
  else $error("mode format bits not stored");

  AST_POWER_WRITE: // R23
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_TOUCH
    |=> touch_o.power == $past(host_wdata_i[3:0]))
  else $error("touch pin power not stored");

  AST_OP_WRITE: // R2
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_TOUCH
    |=> touch_o.op_select == $past(host_wdata_i[9:8]))
  else $error("touch mode field not stored");

  AST_REF_INPUT_WRITE: // R7
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_CONV_CTL
    |=> conv_o.internal_ref_to_pin == $past(host_wdata_i[1])
    && conv_o.input_select == $past(host_wdata_i[4:2]))
  else $error("reference or input select not stored");

  AST_START_HELD: // R10
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_CONV_CTL
    && conv_o.start |=> !conv_start_o)
  else $error("start launched while bit already set");

  AST_RESULT_READ: // R12
  assert property (host_rd_i && host_addr_i == tac_pkg::TAC_ADDR_CONV_RES
    |=> host_rdata_o[14:5] == $past(st_r.result)
    && host_rdata_o[4:0] == 5'h00)
  else $error("result field read wrong");

  AST_DONE_READ: // R13
  assert property (host_rd_i && host_addr_i == tac_pkg::TAC_ADDR_CONV_RES
    |=> host_rdata_o[15] == $past(st_r.conversion_done))
  else $error("done bit read wrong");

  AST_DONE_HOLD: // R13
  assert property (st_r.conversion_done
    |=> st_r.conversion_done || conv_start_o)
  else $error("done flag dropped without a start");

  AST_RESULT_HOLD: // R12
  assert property (!conv_done_i |=> $stable(st_r.result))
  else $error("result changed without a conversion");

  AST_ID_READ: // R14
  assert property (host_rd_i && host_addr_i == tac_pkg::TAC_ADDR_ID
    |=> host_rdata_o == {MAKER_CODE, DEVICE_CODE, VERSION_CODE})
  else $error("identification word wrong");

  AST_TEST_WRITE: // R15 R16 R17
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_MODE
    && st_r.test_s2
    |=> mode_o.audio_analog_test == $past(host_wdata_i[0])
    && mode_o.telecom_analog_test == $past(host_wdata_i[1])
    && mode_o.production_test_select == $past(host_wdata_i[5:2]))
  else $error("test bits not stored");

  AST_DYN_FLAG_WRITE: // R18
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_MODE
    |=> mode_o.dynamic_valid_flag_on == $past(host_wdata_i[12]))
  else $error("dynamic flag bit not stored");

  AST_RSVD_WRITE: // R21
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_RSVD
    |=> $stable(touch_o) && $stable(conv_o) && $stable(mode_o))
  else $error("reserved write changed state");

  AST_ONES_WRITE: // R22
  assert property (host_wr_i && host_addr_i == tac_pkg::TAC_ADDR_ONES
    |=> $stable(touch_o) && $stable(conv_o) && $stable(mode_o))
  else $error("all-ones write changed state");

endmodule : tac_regs

// ===== rtl/tac_pkg.sv
// Contract
// R1: Ground bits 4-7 ground touch pins
// R2: Mode field: 00 irq, 01 pressure, 1x position
// R3: Bit 11 switches touch bias on
// R4: Bit 12 reads inverted positive-X pin
// R5: Bit 13 reads inverted negative-X pin
// R6: Converter bit 0 enables sync mode
// R7: Converter bit 1 ties internal reference out
// R8: Input select bits 2-4 route converter input
// R9: Bit 5 selects external reference, resets zero
// R10: Conversion starts only on bit 7 rise
// R11: Converter bit 15 powers converter
// R12: Result bits 5-14, read-only, reset zero
// R13: Result bit 15 flags finished conversion
// R14: Identification register returns fixed codes
// R15: Mode bit 0 enables audio test
// R16: Mode bit 1 enables telecom test
// R17: Mode bits 2-5 pick production test
// R18: Mode bit 12 enables dynamic valid flags
// R19: Mode bit 13 enables audio offset cancel
// R20: Mode bits 14/15 select big-endian words
// R21: Address 14 reserved, writes ignored
// R22: Address 15 always reads all ones
// R23: Touch bits 0-3 power touch pins
// R24: Test-mode writes need test-enable pin high
package tac_pkg;

  localparam logic [3:0] TAC_ADDR_TOUCH = 4'h9;
  localparam logic [3:0] TAC_ADDR_CONV_CTL = 4'ha;
  localparam logic [3:0] TAC_ADDR_CONV_RES = 4'hb;
  localparam logic [3:0] TAC_ADDR_ID = 4'hc;
  localparam logic [3:0] TAC_ADDR_MODE = 4'hd;
  localparam logic [3:0] TAC_ADDR_RSVD = 4'he;
  localparam logic [3:0] TAC_ADDR_ONES = 4'hf;

  localparam int TAC_TP_POWER_LSB = 0;
  localparam int TAC_TP_GROUND_LSB = 4;
  localparam int TAC_TP_OP_LSB = 8;
  localparam int TAC_TP_BIAS = 11;
  localparam int TAC_TP_PX_DOWN = 12;
  localparam int TAC_TP_MX_DOWN = 13;

  localparam int TAC_CC_SYNC = 0;
  localparam int TAC_CC_REF_PIN = 1;
  localparam int TAC_CC_INPUT_LSB = 2;
  localparam int TAC_CC_EXT_REF = 5;
  localparam int TAC_CC_START = 7;
  localparam int TAC_CC_POWER = 15;

  localparam int TAC_CR_DATA_LSB = 5;
  localparam int TAC_CR_DONE = 15;

  localparam int TAC_ID_DEVICE_LSB = 6;
  localparam int TAC_ID_MAKER_LSB = 12;

  localparam int TAC_MD_AUDIO_TEST = 0;
  localparam int TAC_MD_TELECOM_ANALOG_TEST = 1;
  localparam int TAC_MD_PROD_LSB = 2;
  localparam int TAC_MD_DYN_FLAG = 12;
  localparam int TAC_MD_OFFSET = 13;
  localparam int TAC_MD_AUDIO_ORDER = 14;
  localparam int TAC_MD_TEL_ORDER = 15;

  localparam logic [15:0] TAC_WORD_ZERO = 16'h0000;
  localparam logic [15:0] TAC_WORD_ONES = 16'hffff;

  typedef struct packed {
    logic [3:0] power;
    logic [3:0] ground;
    logic [1:0] op_select;
    logic bias_on;
  } tac_touch_ctl_t;

  typedef struct packed {
    logic interrupt_mode;
    logic pressure_mode;
    logic position_mode;
  } tac_touch_mode_t;

  typedef struct packed {
    logic sync_on;
    logic internal_ref_to_pin;
    logic [2:0] input_select;
    logic external_reference_select;
    logic start;
    logic power_on;
  } tac_conv_ctl_t;

  typedef struct packed {
    logic audio_analog_test;
    logic telecom_analog_test;
    logic [3:0] production_test_select;
    logic dynamic_valid_flag_on;
    logic audio_offset_cancel;
    logic audio_word_order;
    logic telecom_word_order;
  } tac_mode_t;

  typedef struct packed {
    tac_touch_ctl_t touch;
    tac_conv_ctl_t conv;
    tac_mode_t mode;
    logic [9:0] result;
    logic conversion_done;
    logic conv_start;
    logic px_s1;
    logic px_s2;
    logic mx_s1;
    logic mx_s2;
    logic test_s1;
    logic test_s2;
    logic [15:0] rdata;
    logic rvalid;
  } tac_state_t;

endpackage : tac_pkg

// ===== tb/tac_conv_model.sv
`timescale 1ns/1ps
module tac_conv_model #(
  parameter int DELAY = 6,
  parameter logic [9:0] RESULT = 10'h2a5
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic conv_start_i,
  output logic conv_done_o,
  output logic [9:0] conv_result_o
);
  int cnt;

  // Result lines carry junk outside the done cycle
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 0;
      conv_done_o <= 1'b0;
      conv_result_o <= ~RESULT;
    end
    else
    begin
      conv_done_o <= 1'b0;
      conv_result_o <= ~RESULT;
      if (conv_start_i)
        cnt <= DELAY;
      else if (cnt > 0)
      begin
        cnt <= cnt - 1;
        if (cnt == 1)
        begin
          conv_done_o <= 1'b1;
          conv_result_o <= RESULT;
        end
      end
    end
  end
endmodule : tac_conv_model

// ===== tb/touch_adc_control_regs_tb.sv
`timescale 1ns/1ps
module touch_adc_control_regs_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic host_wr_i = 1'b0;
  logic host_rd_i = 1'b0;
  logic [3:0] host_addr_i = 4'h0;
  logic [15:0] host_wdata_i = 16'h0000;
  logic pos_x_pin_i = 1'b1;
  logic neg_x_pin_i = 1'b1;
  logic test_enable_i = 1'b0;
  logic conv_done_i;
  logic [9:0] conv_result_i;
  logic [15:0] host_rdata_o;
  logic host_rvalid_o;
  tac_pkg::tac_touch_ctl_t touch_o;
  tac_pkg::tac_touch_mode_t touch_mode_o;
  tac_pkg::tac_conv_ctl_t conv_o;
  logic [7:0] conv_route_o;
  logic conv_start_o;
  tac_pkg::tac_mode_t mode_o;
  int miscompares = 0;
  int total_checks = 0;
  int starts = 0;
  logic [15:0] rv;
  logic [15:0] w;
  logic [2:0] sel;
  logic [15:0] m;

  tac_regs tac_regs_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o), .pos_x_pin_i(pos_x_pin_i),
    .neg_x_pin_i(neg_x_pin_i), .test_enable_i(test_enable_i),
    .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
    .touch_o(touch_o), .touch_mode_o(touch_mode_o), .conv_o(conv_o),
    .conv_route_o(conv_route_o), .conv_start_o(conv_start_o),
    .mode_o(mode_o)
  );

  tac_conv_model tac_conv_model_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .conv_start_i(conv_start_o),
    .conv_done_o(conv_done_i), .conv_result_o(conv_result_i)
  );

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
    if (conv_start_o === 1'b1) starts <= starts + 1;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    host_wr_i = 1'b1;
    host_addr_i = a;
    host_wdata_i = d;
    @(negedge mclk_i);
    host_wr_i = 1'b0;
    host_wdata_i = ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge mclk_i);
    host_rd_i = 1'b1;
    host_addr_i = a;
    @(negedge mclk_i);
    host_rd_i = 1'b0;
    chk({15'h0, host_rvalid_o}, 16'h0001);
    d = host_rdata_o;
  endtask : rd

  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdchk

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(negedge mclk_i);
    rst_i = 1'b0;
    rdchk(4'h9, 16'h0000);
    rdchk(4'ha, 16'h0000);
    rdchk(4'hb, 16'h0000);
    rdchk(4'hc, 16'h3081);
    rdchk(4'hd, 16'h0000);
    rdchk(4'he, 16'h0000);
    rdchk(4'hf, 16'hffff);
    chk({13'h0, touch_mode_o}, 16'h0004);
    chk({8'h0, conv_route_o}, 16'h0001);
    $display("test reset done");
    wr(4'h9, 16'h0bff);
    chk({5'h0, touch_o}, 16'h07ff);
    rdchk(4'h9, 16'h0bff);
    pos_x_pin_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    rdchk(4'h9, 16'h1bff);
    pos_x_pin_i = 1'b1;
    neg_x_pin_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    rdchk(4'h9, 16'h2bff);
    neg_x_pin_i = 1'b1;
    wr(4'h9, 16'h00a0);
    chk({5'h0, touch_o}, 16'h0050);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h9, 16'(i) << 8);
      m = (i == 0) ? 16'h4 : (i == 1) ? 16'h2 : 16'h1;
      chk({13'h0, touch_mode_o}, m);
    end
    $display("test touch done");
    for (int i = 0; i < 8; i++)
    begin
      sel = i[2:0];
      w = 16'h8023 | (16'(sel) << 2);
      wr(4'ha, w);
      chk({8'h0, conv_o}, {8'h0, 2'b11, sel, 3'b101});
      chk({8'h0, conv_route_o}, 16'h0001 << sel);
      rdchk(4'ha, w);
    end
    wr(4'ha, 16'h0000);
    chk({8'h0, conv_o}, 16'h0000);
    $display("test converter control done");
    wr(4'ha, 16'h8080);
    chk({15'h0, conv_start_o}, 16'h0001);
    rdchk(4'hb, 16'h0000);
    repeat (10) @(negedge mclk_i);
    rdchk(4'hb, 16'hd4a0);
    wr(4'hb, 16'h0000);
    rdchk(4'hb, 16'hd4a0);
    wr(4'hc, 16'h0000);
    rdchk(4'hc, 16'h3081);
    wr(4'ha, 16'h8080);
    repeat (3) @(negedge mclk_i);
    chk(16'(starts), 16'h0001);
    wr(4'ha, 16'h8000);
    wr(4'ha, 16'h8080);
    rd(4'hb, rv);
    chk({15'h0, rv[15]}, 16'h0000);
    chk(16'(starts), 16'h0002);
    $display("test conversion done");
    wr(4'hd, 16'hffff);
    chk({6'h00, mode_o}, 16'h000f);
    rdchk(4'hd, 16'hf000);
    test_enable_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    wr(4'hd, 16'hffff);
    chk({6'h00, mode_o}, 16'h03ff);
    rdchk(4'hd, 16'hf03f);
    wr(4'hd, 16'h0014);
    chk({6'h00, mode_o}, 16'h0050);
    test_enable_i = 1'b0;
    $display("test mode done");
    wr(4'he, 16'h1234);
    wr(4'hf, 16'h0000);
    rdchk(4'he, 16'h0000);
    rdchk(4'hf, 16'hffff);
    $display("test reserved done");
    rst_i = 1'b1;
    @(negedge mclk_i);
    rst_i = 1'b0;
    rdchk(4'h9, 16'h0000);
    rdchk(4'ha, 16'h0000);
    rdchk(4'hb, 16'h0000);
    rdchk(4'hd, 16'h0000);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : touch_adc_control_regs_tb
